// ===== design/motor_config_shadow_bank.sv
`timescale 1ns/100ps
`default_nettype none
module motor_config_shadow_bank
    import motor_config_pkg::*;
#(
    parameter logic [DATA_W-1:0] TRIM_VALUE = 18'h00000  // arbitrary neutral trim
) (
    input  wire logic              mclk_in,
    input  wire logic              reset_in,
    input  wire logic              reg_req_in,
    input  wire logic              reg_write_in,
    input  wire logic [ADDR_W-1:0] reg_addr_in,
    input  wire logic [DATA_W-1:0] reg_wdata_in,
    input  wire logic [8:0]        demand_in,
    input  wire logic              dir_pin_in,
    input  wire logic              stop_pin_in,
    input  wire logic              host_direction_in,
    input  wire logic [11:0]       phase_current_in,
    input  wire logic [11:0]       rated_current_in,
    output var  logic              reg_ack_out,
    output var  logic [DATA_W-1:0] reg_rdata_out,
    output var  logic              config_ready_out,
    output var  logic [12:0]       position_detect_threshold_out,
    output var  logic [9:0]        shunt_tenth_milliohm_out,
    output var  logic [8:0]        rated_decivolt_out,
    output var  logic              standby_block_out,
    output var  logic [7:0]        nudge_start_amplitude_out,
    output var  logic [1:0]        vds_threshold_volt_out,
    output var  logic [3:0]        restart_wait_s_out,
    output var  logic [3:0]        restart_limit_out,
    output var  logic [2:0]        rampdown_s_out,
    output var  logic              rampdown_long_out,
    output var  logic              brake_apply_out,
    output var  logic [5:0]        clock_ratio_quarter_out,
    output var  logic              ratio_invalid_out,
    output var  logic [8:0]        demand_effective_out,
    output var  logic              motor_stop_out,
    output var  logic              direction_out,
    output var  logic [1:0]        loop_mode_out,
    output var  logic [10:0]       setpoint_out,
    output var  logic [14:0]       inductance_out,
    output var  logic [7:0]        winding_resistance_out,
    output var  logic [8:0]        torque_constant_value_out,
    output var  logic [2:0]        current_ki_out,
    output var  logic [4:0]        power_kp_out,
    output var  logic [4:0]        speed_kp_out,
    output var  logic [4:0]        current_kp_out,
    output var  logic [2:0]        power_ki_out,
    output var  logic [2:0]        speed_ki_out
);

    typedef struct packed {
        logic [NV_WORDS-1:0][DATA_W-1:0]     nv;
        logic [SHADOW_WORDS-1:0][DATA_W-1:0] shadow;
        phase_t      phase;
        logic [4:0]  walk;
        logic [1:0]  dir_sync;
        logic [1:0]  stop_sync;
        logic        ack;
        logic [DATA_W-1:0] rdata;
        logic        ready;
        logic [12:0] detect_ma;
        logic [9:0]  shunt;
        logic [8:0]  volt;
        logic        standby_block;
        logic [7:0]  nudge;  // top code gives 248 tenths, past seven bits
        logic [1:0]  vds;
        logic [3:0]  wait_s;
        logic [3:0]  limit;
        logic [2:0]  ramp_s;
        logic        ramp_long;
        logic        brake;
        logic [5:0]  ratio;
        logic        ratio_bad;
        logic [8:0]  demand;
        logic        stop;
        logic        dir;
        logic [1:0]  mode;
        logic [10:0] setpoint;
        logic [14:0] induct;
        logic [7:0]  resist;
        logic [8:0]  kt;
        logic [2:0]  cur_i;
        logic [4:0]  pow_p;
        logic [4:0]  spd_p;
        logic [4:0]  cur_p;
        logic [2:0]  pow_i;
        logic [2:0]  spd_i;
    } bank_state_t;

    bank_state_t st;
    bank_state_t next_st;

    // step curve: output of the last corner whose input does not exceed x
    // corners are assumed stored in rising input order; no interpolation
    function automatic logic [8:0] curve_step(
        input logic [NV_WORDS-1:0][DATA_W-1:0] nv,
        input logic [8:0]                      x
    );
        logic [8:0] y;
        y = 9'h000;
        for (int i = 0; i < SHADOW_WORDS; i++) begin
            if (nv[A_CURVE + i][F_X_LO +: 9] <= x) begin
                y = nv[A_CURVE + i][F_Y_LO +: 9];
            end
        end
        return y;
    endfunction

    // stop threshold in demand counts of 511 full scale
    function automatic logic [8:0] off_count(input logic [1:0] code);
        case (code)
            2'b00:   return OFF_CNT_00;
            2'b01:   return OFF_CNT_01;
            2'b10:   return OFF_CNT_10;
            default: return OFF_CNT_11;
        endcase
    endfunction

    // main next-state process
    always_comb begin
        logic [8:0]  curve_out;
        logic [8:0]  mag;
        logic        fwd;
        logic [19:0] product;
        logic        stop_request;
        logic [11:0] safe_limit;
        logic [DATA_W-1:0] w15;
        logic [DATA_W-1:0] w18;
        logic [DATA_W-1:0] w20;
        logic [DATA_W-1:0] w21;
        logic [DATA_W-1:0] w22;
        logic [DATA_W-1:0] w23;
        logic [DATA_W-1:0] w25;
        logic [DATA_W-1:0] w28;
        logic [DATA_W-1:0] w29;
        curve_out    = 9'h000;
        mag          = 9'h000;
        fwd          = 1'b0;
        product      = 20'h00000;
        stop_request = 1'b0;
        safe_limit   = 12'h000;
        next_st      = st;
        w15 = st.shadow[A_SAFE];
        w18 = st.shadow[A_DETECT];
        w20 = st.shadow[A_SHUNT];
        w21 = st.shadow[A_STANDBY];
        w22 = st.shadow[A_PROTECT];
        w23 = st.shadow[A_LOOP];
        w25 = st.shadow[A_BRAKE];
        w28 = st.shadow[A_PI_MAIN];
        w29 = st.shadow[A_PI_INT];

        // pins pass two flops before anything reads them
        next_st.dir_sync  = {st.dir_sync[0], dir_pin_in};
        next_st.stop_sync = {st.stop_sync[0], stop_pin_in};

        // one shadow word copied per cycle after reset
        case (st.phase)
            PH_LOAD: begin
                next_st.shadow[st.walk] = st.nv[st.walk];
                next_st.walk            = st.walk + 5'h01;
                if (st.walk == 5'h1F) begin
                    next_st.phase = PH_RUN;
                    next_st.ready = 1'b1;
                end
            end
            PH_RUN: begin
                next_st.ready = 1'b1;
            end
            default: begin
                next_st.phase = PH_LOAD;
                next_st.walk  = 5'h00;
                next_st.ready = 1'b0;
            end
        endcase

        // host access; writes land after the copy so a racing write wins
        next_st.ack = reg_req_in;
        if (reg_req_in) begin
            if (reg_addr_in < ADDR_W'(NV_WORDS)) begin
                next_st.rdata = st.nv[reg_addr_in[5:0]];
            end else if (reg_addr_in < ADDR_W'(SHADOW_BASE + SHADOW_WORDS)) begin
                next_st.rdata = st.shadow[reg_addr_in[4:0]];
            end else begin
                next_st.rdata = NV_RESET;
            end
            if (reg_write_in && reg_addr_in < ADDR_W'(NV_WORDS)
                && reg_addr_in != ADDR_W'(A_TRIM)) begin
                next_st.nv[reg_addr_in[5:0]] = reg_wdata_in;
                // words below 32 are written through to their shadow
                if (reg_addr_in < ADDR_W'(SHADOW_WORDS)) begin
                    next_st.shadow[reg_addr_in[4:0]] = reg_wdata_in;
                end
            end
        end

        // scaled settings from the shadow copies
        next_st.detect_ma = 13'(w18[F_DETECT_LO +: 6]) * DETECT_MA_PER_COUNT;
        next_st.shunt = 10'((15'(w20[F_SHUNT_LO +: 8]) * SHUNT_TENTH_NUM)
                            / SHUNT_DEN);
        next_st.volt = 9'(w20[F_VOLT_LO +: 8]) * VOLT_DV_PER_COUNT;
        next_st.standby_block = w21[F_STANDBY];
        next_st.nudge = 8'(w21[F_NUDGE_LO +: 3]) * 8'(NUDGE_STEP_PERMILLE)
                        + 8'(NUDGE_BASE_PERMILLE);
        next_st.vds = w22[F_VDS] ? VDS_HIGH_V : VDS_LOW_V;
        next_st.wait_s = w22[F_WAIT] ? WAIT_LONG_S : WAIT_SHORT_S;
        case (w22[F_ATTEMPT_LO +: 2])
            2'b01:   next_st.limit = ATTEMPT_01;
            2'b10:   next_st.limit = ATTEMPT_10;
            2'b11:   next_st.limit = ATTEMPT_11;
            default: next_st.limit = ATTEMPT_UNLIMITED;
        endcase
        next_st.ramp_long = w22[F_RAMP];
        next_st.ramp_s    = w22[F_RAMP] ? RAMP_LONG_S : RAMP_SHORT_S;
        // ratio passed as stored; an oversize value is flagged, not clipped
        next_st.ratio     = w22[F_RATIO_LO +: 6];
        next_st.ratio_bad = w22[F_RATIO_LO +: 6] > RATIO_MAX;

        // demand path: optional curve, then direction split
        curve_out = w23[F_CURVE_EN] ? curve_step(st.nv, demand_in) : demand_in;
        if (w23[F_BIDIR]) begin
            fwd = curve_out > BIDIR_CENTRE;
            mag = fwd ? {8'(curve_out - BIDIR_CENTRE - 9'h001), 1'b0}
                      : {8'(BIDIR_CENTRE - curve_out), 1'b0};
            next_st.dir = fwd;
        end else begin
            mag = curve_out;
            next_st.dir = w25[F_DIR_SRC] ? host_direction_in : st.dir_sync[1];
        end
        next_st.demand = mag;
        next_st.stop   = mag < off_count(w21[F_OFF_LO +: 2]);

        // control loop and setpoint
        next_st.mode = w23[F_MODE_LO +: 2];
        product = 20'(w23[F_FULL_LO +: 11]) * 20'(mag);
        if (w23[F_MODE_LO +: 2] == MODE_OPEN) begin
            next_st.setpoint = 11'h000;
        end else if (mag == DEMAND_FULL) begin
            next_st.setpoint = w23[F_FULL_LO +: 11];
        end else begin
            next_st.setpoint = product[19:9];
        end

        // braking: source select, then safe-current gate
        stop_request = w25[F_STOP_SRC] ? w25[F_STOP_REQ] : st.stop_sync[1];
        safe_limit   = rated_current_in >> w15[F_SAFE_LO +: 3];
        next_st.brake = stop_request
                        && (w22[F_BRAKE_MODE] || phase_current_in < safe_limit);

        // motor parameters and loop gains
        next_st.induct = 15'(w25[F_IND_LO +: 8]) << w25[F_SHIFT_LO +: 3];
        next_st.resist = st.shadow[A_RESIST][F_RES_LO +: 8];
        next_st.kt     = st.shadow[A_TORQUE][F_KT_LO +: 9];
        next_st.cur_i  = w28[F_CUR_I_LO +: 3];
        next_st.pow_p  = w28[F_POW_P_LO +: 5];
        next_st.spd_p  = w28[F_SPD_P_LO +: 5];
        next_st.cur_p  = w28[F_CUR_P_LO +: 5];
        next_st.pow_i  = w29[F_POW_I_LO +: 3];
        next_st.spd_i  = w29[F_SPD_I_LO +: 3];

        // reset clears the store except the trim word, which takes TRIM_VALUE, clears decoded outputs, then restarts the copy
        if (reset_in) begin
            next_st = '0;
            for (int i = 0; i < NV_WORDS; i++) begin
                next_st.nv[i] = NV_RESET;
            end
            next_st.nv[A_TRIM] = TRIM_VALUE;
            next_st.phase      = PH_LOAD;
        end
    end

    // single state register
    always_ff @(posedge mclk_in) begin
        st <= next_st;
    end

    // outputs straight from flops
    assign reg_ack_out                   = st.ack;
    assign reg_rdata_out                 = st.rdata;
    assign config_ready_out              = st.ready;
    assign position_detect_threshold_out = st.detect_ma;
    assign shunt_tenth_milliohm_out      = st.shunt;
    assign rated_decivolt_out            = st.volt;
    assign standby_block_out             = st.standby_block;
    assign nudge_start_amplitude_out     = st.nudge;
    assign vds_threshold_volt_out        = st.vds;
    assign restart_wait_s_out            = st.wait_s;
    assign restart_limit_out             = st.limit;
    assign rampdown_s_out                = st.ramp_s;
    assign rampdown_long_out             = st.ramp_long;
    assign brake_apply_out               = st.brake;
    assign clock_ratio_quarter_out       = st.ratio;
    assign ratio_invalid_out             = st.ratio_bad;
    assign demand_effective_out          = st.demand;
    assign motor_stop_out                = st.stop;
    assign direction_out                 = st.dir;
    assign loop_mode_out                 = st.mode;
    assign setpoint_out                  = st.setpoint;
    assign inductance_out                = st.induct;
    assign winding_resistance_out        = st.resist;
    assign torque_constant_value_out     = st.kt;
    assign current_ki_out                = st.cur_i;
    assign power_kp_out                  = st.pow_p;
    assign speed_kp_out                  = st.spd_p;
    assign current_kp_out                = st.cur_p;
    assign power_ki_out                  = st.pow_i;
    assign speed_ki_out                  = st.spd_i;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    sequence s_write_trim;
        reg_req_in && reg_write_in && reg_addr_in == ADDR_W'(A_TRIM);
    endsequence
    sequence s_read_nv;
        reg_req_in && !reg_write_in && reg_addr_in < ADDR_W'(NV_WORDS);
    endsequence

    chk_trim_locked: assert property (s_write_trim |=> st.nv[A_TRIM] == $past(st.nv[A_TRIM]))
        else $error("trim word changed by a write");
    chk_read_word: assert property (s_read_nv ##1 1'b1 |-> reg_ack_out
        && reg_rdata_out == $past(st.nv[reg_addr_in[5:0]]))
        else $error("register read did not return the stored word");
    chk_load_done: assert property ($fell(reset_in) |-> ##[31:34] config_ready_out)
        else $error("shadow copy did not finish in time");
    chk_detect_scale: assert property (config_ready_out |=>
        position_detect_threshold_out == 13'($past(st.shadow[A_DETECT][F_DETECT_LO +: 6])) * 13'd86)
        else $error("detect threshold scale wrong");
    chk_restart_limit: assert property (config_ready_out
        && st.shadow[A_PROTECT][F_ATTEMPT_LO +: 2] == 2'b11 |=> restart_limit_out == 4'hA)
        else $error("restart limit decode wrong");
    chk_ramp_time: assert property (config_ready_out |=>
        rampdown_s_out == ($past(st.shadow[A_PROTECT][F_RAMP]) ? 3'h4 : 3'h1))
        else $error("rampdown time wrong");
    chk_vds_level: assert property (config_ready_out |=>
        vds_threshold_volt_out == ($past(st.shadow[A_PROTECT][F_VDS]) ? 2'h2 : 2'h1))
        else $error("vds threshold wrong");
    chk_nudge_value: assert property (config_ready_out |=> nudge_start_amplitude_out
        == 8'($past(st.shadow[A_STANDBY][F_NUDGE_LO +: 3])) * 8'd32 + 8'd24)
        else $error("nudge amplitude wrong");
    chk_stop_low: assert property (config_ready_out && !st.shadow[A_LOOP][F_CURVE_EN]
        && !st.shadow[A_LOOP][F_BIDIR] && st.shadow[A_STANDBY][F_OFF_LO +: 2] == 2'b00
        && demand_in < 9'd50 |=> motor_stop_out)
        else $error("motor not stopped below threshold");
    chk_brake_now: assert property (config_ready_out && st.shadow[A_BRAKE][F_STOP_SRC]
        && st.shadow[A_BRAKE][F_STOP_REQ] && st.shadow[A_PROTECT][F_BRAKE_MODE]
        |=> brake_apply_out)
        else $error("immediate brake not applied");

endmodule
`default_nettype wire

// ===== design/motor_config_pkg.sv
// Behaviour
// - position-detect threshold bits 13:8 of word 18, 0.086 A per count
// - shunt bits 15:8 of word 20 read as milliohms, value over 3.7
// - rated voltage bits 7:0 of word 20, volts equal value over five
// - word 21 bit 15 set keeps the device out of standby
// - stop below threshold 9.7/5.8/12.8/19.5 percent, taken after the curve
// - nudge start amplitude percent equals bits 7:5 of word 21 times 3.2 plus 2.4
// - word 22 bit 15 picks 1 V or 2 V short-circuit threshold
// - lock restart wait 5 s or 10 s by word 22 bit 11
// - restart attempts unlimited, 3, 5 or 10 by word 22 bits 7:6
// - stop ramp-down lasts 1 s or 4 s by word 22 bit 9
// - word 22 bit 8 clear brakes when safe, set brakes at once
// - clock ratio 0.25 rpm/Hz per count; host keeps it at 41 or less
// - word 23 bit 17 routes demand through the curve, else bypasses it
// - bidirectional curve: 0 full reverse, 511 full forward, 255 stop
// - word 23 bits 12:11 pick open loop, torque, speed or power
// - closed-loop setpoint is full scale times demand ratio
// - stop follows pin, or word 25 bit 15 when bit 14 set
// - with word 23 bit 16 clear, direction from pin, or from direction register when word 25 bit 13 set
// - inductance equals word 25 bits 7:0 shifted by bits 10:8
// - word 24 bits 7:0 are phase to centre-tap resistance
// - PI gains unpacked from words 28 and 29 fields
// - words 32 to 63 hold curve corners, input 17:9, output 8:0, unshadowed
// - safe-brake threshold is rated current halved per code step
// - each stored word is read at register address equal to its word number
package motor_config_pkg;
    localparam int DATA_W       = 18;
    localparam int ADDR_W       = 8;
    localparam int NV_WORDS     = 64;
    localparam int SHADOW_WORDS = 32;
    localparam int SHADOW_BASE  = 64;

    // word numbers, equal to their register addresses
    localparam int A_SAFE    = 15;
    localparam int A_DETECT  = 18;
    localparam int A_SHUNT   = 20;
    localparam int A_STANDBY = 21;
    localparam int A_PROTECT = 22;
    localparam int A_LOOP    = 23;
    localparam int A_RESIST  = 24;
    localparam int A_BRAKE   = 25;
    localparam int A_TORQUE  = 26;
    localparam int A_PI_MAIN = 28;
    localparam int A_PI_INT  = 29;
    localparam int A_TRIM    = 31;
    localparam int A_CURVE   = 32;

    // field positions
    localparam int F_SAFE_LO     = 14;
    localparam int F_DETECT_LO   = 8;
    localparam int F_SHUNT_LO    = 8;
    localparam int F_VOLT_LO     = 0;
    localparam int F_STANDBY     = 15;
    localparam int F_OFF_LO      = 8;
    localparam int F_NUDGE_LO    = 5;
    localparam int F_VDS         = 15;
    localparam int F_WAIT        = 11;
    localparam int F_RAMP        = 9;
    localparam int F_BRAKE_MODE  = 8;
    localparam int F_ATTEMPT_LO  = 6;
    localparam int F_RATIO_LO    = 0;
    localparam int F_CURVE_EN    = 17;
    localparam int F_BIDIR       = 16;
    localparam int F_MODE_LO     = 11;
    localparam int F_FULL_LO     = 0;
    localparam int F_RES_LO      = 0;
    localparam int F_STOP_REQ    = 15;
    localparam int F_STOP_SRC    = 14;
    localparam int F_DIR_SRC     = 13;
    localparam int F_SHIFT_LO    = 8;
    localparam int F_IND_LO      = 0;
    localparam int F_KT_LO       = 0;
    localparam int F_CUR_I_LO    = 15;
    localparam int F_POW_P_LO    = 10;
    localparam int F_SPD_P_LO    = 5;
    localparam int F_CUR_P_LO    = 0;
    localparam int F_POW_I_LO    = 3;
    localparam int F_SPD_I_LO    = 0;
    localparam int F_X_LO        = 9;
    localparam int F_Y_LO        = 0;

    // scaling and decode tables
    localparam logic [12:0] DETECT_MA_PER_COUNT = 13'h0056;
    localparam logic [14:0] SHUNT_TENTH_NUM     = 15'h0064;
    localparam logic [14:0] SHUNT_DEN           = 15'h0025;
    localparam logic [8:0]  VOLT_DV_PER_COUNT   = 9'h002;
    localparam logic [6:0]  NUDGE_STEP_PERMILLE = 7'h20;
    localparam logic [6:0]  NUDGE_BASE_PERMILLE = 7'h18;
    localparam logic [8:0]  OFF_CNT_00          = 9'h032;
    localparam logic [8:0]  OFF_CNT_01          = 9'h01E;
    localparam logic [8:0]  OFF_CNT_10          = 9'h041;
    localparam logic [8:0]  OFF_CNT_11          = 9'h064;
    localparam logic [1:0]  VDS_LOW_V           = 2'h1;
    localparam logic [1:0]  VDS_HIGH_V          = 2'h2;
    localparam logic [3:0]  WAIT_SHORT_S        = 4'h5;
    localparam logic [3:0]  WAIT_LONG_S         = 4'hA;
    localparam logic [2:0]  RAMP_SHORT_S        = 3'h1;
    localparam logic [2:0]  RAMP_LONG_S         = 3'h4;
    localparam logic [3:0]  ATTEMPT_UNLIMITED   = 4'h0;
    localparam logic [3:0]  ATTEMPT_01          = 4'h3;
    localparam logic [3:0]  ATTEMPT_10          = 4'h5;
    localparam logic [3:0]  ATTEMPT_11          = 4'hA;
    localparam logic [5:0]  RATIO_MAX           = 6'h29;
    localparam logic [8:0]  DEMAND_FULL         = 9'h1FF;
    localparam logic [8:0]  BIDIR_CENTRE        = 9'h0FF;
    localparam logic [1:0]  MODE_OPEN           = 2'h0;
    localparam logic [DATA_W-1:0] NV_RESET      = 18'h00000;

    typedef enum logic [1:0] {
        PH_LOAD = 2'b01,
        PH_RUN  = 2'b10
    } phase_t;
endpackage

// ===== verification/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model
    import motor_config_pkg::*;
(
    input  wire logic              mclk_in,
    output var  logic              req_out,
    output var  logic              write_out,
    output var  logic [ADDR_W-1:0] addr_out,
    output var  logic [DATA_W-1:0] wdata_out
);
    initial {req_out, write_out, addr_out, wdata_out} = '0;
    // one-cycle request per access; gap idles the host to act slowly
    task automatic access(input logic w, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d, input int gap);
        logic [DATA_W-1:0] v;
        v = d;
        // ratios past the ceiling misbehave, so the host never sends them
        if (w && a == A_PROTECT && v[5:0] > RATIO_MAX) v[5:0] = RATIO_MAX;
        @(posedge mclk_in);
        req_out   <= 1'b1;
        write_out <= w;
        addr_out  <= a;
        wdata_out <= v;
        @(posedge mclk_in);
        req_out <= 1'b0;
        repeat (gap) @(posedge mclk_in);
    endtask
endmodule
`default_nettype wire

// ===== verification/motor_config_shadow_bank_test.sv
`timescale 1ns/100ps
`default_nettype none
module motor_config_shadow_bank_test
    import motor_config_pkg::*;
;
    localparam logic [DATA_W-1:0] TRIM = 18'h2A5C5; // arbitrary trim pattern
    logic mclk_in, reset_in, req, wr, ack, ready, hdir, std, brk, stp, dir, dpin, spin;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, d, p;
    logic [8:0] demand, volt;
    logic [11:0] phc, ratc;
    logic [12:0] det;
    logic [9:0] shunt;
    logic [7:0] nudge;
    logic [1:0] vds;
    logic [3:0] wt, lim;
    logic [2:0] ramp;
    logic [5:0] ratio;
    logic [10:0] setp;
    logic [14:0] ind;
    logic [18:0] n;
    logic [18:0] expq[$];
    integer bad_count, check_count, seed, i;
    host_model host (.mclk_in(mclk_in), .req_out(req), .write_out(wr), .addr_out(addr),
        .wdata_out(wdata));
    motor_config_shadow_bank #(.TRIM_VALUE(TRIM)) dut (.mclk_in(mclk_in), .reset_in(reset_in),
        .reg_req_in(req), .reg_write_in(wr), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .demand_in(demand), .dir_pin_in(dpin), .stop_pin_in(spin), .host_direction_in(hdir),
        .phase_current_in(phc), .rated_current_in(ratc), .reg_ack_out(ack),
        .reg_rdata_out(rdata), .config_ready_out(ready), .position_detect_threshold_out(det),
        .shunt_tenth_milliohm_out(shunt), .rated_decivolt_out(volt), .standby_block_out(std),
        .nudge_start_amplitude_out(nudge), .vds_threshold_volt_out(vds),
        .restart_wait_s_out(wt), .restart_limit_out(lim), .rampdown_s_out(ramp),
        .rampdown_long_out(), .brake_apply_out(brk), .clock_ratio_quarter_out(ratio),
        .ratio_invalid_out(), .demand_effective_out(), .motor_stop_out(stp),
        .direction_out(dir), .loop_mode_out(), .setpoint_out(setp), .inductance_out(ind),
        .winding_resistance_out(), .torque_constant_value_out(), .current_ki_out(),
        .power_kp_out(), .speed_kp_out(), .current_kp_out(), .power_ki_out(), .speed_ki_out());
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (e !== g) begin
            bad_count++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    // settings land one cycle after the ack, so give them three
    task automatic wrw(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        expq.push_back({1'b0, v});
        host.access(1'b1, a, v, $unsigned($random(seed)) % 3);
        repeat (3) @(posedge mclk_in);
        @(negedge mclk_in);
    endtask
    task automatic rdw(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        expq.push_back({1'b1, e});
        host.access(1'b0, a, '0, 0);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end
    // every ack retires the oldest note; read notes carry the expected word
    always @(posedge mclk_in) begin
        if (ack === 1'b1) begin
            if (expq.size() == 0) chk("unexpected ack", 0, 1);
            else begin
                n = expq.pop_front();
                if (n[18]) chk("rdata", n[17:0], rdata);
            end
        end
    end
    initial begin
        #1000000;
        bad_count++;
        summarize();
    end
    initial begin
        seed = 53058; bad_count = 0; check_count = 0;
        reset_in = 1'b1; demand = 9'h000; hdir = 1'b0; phc = 12'hFFF; ratc = 12'h100;
        dpin = 1'b0; spin = 1'b0;
        repeat (20) @(posedge mclk_in);
        reset_in <= 1'b0;
        repeat (33) @(posedge mclk_in);
        @(negedge mclk_in);
        chk("ready", 1, ready);
        wrw(A_TRIM, ~TRIM);
        rdw(A_TRIM, TRIM);
        rdw(SHADOW_BASE + A_TRIM, TRIM);
        for (i = 0; i < 4; i++) begin
            p = $random(seed);
            p[5:0] = p[5:0] % 42;
            p[7:6] = i[1:0];
            wrw(A_PROTECT, p);
            rdw(A_PROTECT, p);
            chk("limit", i == 0 ? 0 : i == 1 ? 3 : i == 2 ? 5 : 10, lim);
            chk("vds", p[15] ? 2 : 1, vds);
            chk("wait", p[11] ? 10 : 5, wt);
            chk("ramp", p[9] ? 4 : 1, ramp);
            chk("ratio", p[5:0], ratio);
        end
        d = $random(seed);
        wrw(A_SHUNT, d);
        rdw(SHADOW_BASE + A_SHUNT, d);
        chk("shunt", d[15:8] * 100 / 37, shunt);
        chk("volt", d[7:0] * 2, volt);
        d = $random(seed);
        wrw(A_DETECT, d);
        chk("detect", d[13:8] * 86, det);
        d = $random(seed);
        d[9:8] = 2'b00;
        wrw(A_STANDBY, d);
        chk("standby", d[15], std);
        chk("nudge", d[7:5] * 32 + 24, nudge);
        chk("stop low", 1, stp);
        demand <= 9'h032;
        wrw(A_LOOP, {7'h02, d[10:0]});
        chk("stop high", 0, stp);
        demand <= 9'h1FF;
        wrw(A_LOOP, {7'h01, d[10:0]});
        chk("setpoint", d[10:0], setp);
        wrw(A_LOOP, {7'h00, d[10:0]});
        chk("open setpoint", 0, setp);
        d = $random(seed);
        d[15:13] = 3'b111;
        hdir <= 1'b1;
        wrw(A_BRAKE, d);
        chk("direction", 1, dir);
        chk("inductance", 32'(d[7:0]) << d[10:8], ind);
        chk("brake", p[8], brk);
        d[15] = 1'b0;
        wrw(A_BRAKE, d);
        chk("brake off", 0, brk);
        // pins in charge again; zero current sits under any safe limit
        dpin <= 1'b1; spin <= 1'b1; hdir <= 1'b0; phc <= 12'h000;
        wrw(A_BRAKE, 18'h00000);
        chk("pin direction", 1, dir);
        chk("pin brake", 1, brk);
        summarize();
    end
endmodule
`default_nettype wire
